// *** hdl/mem_map_map.svh ***
// Offsets, field positions, reset values and options of the map registers
`ifndef MEM_MAP_MAP_SVH
`define MEM_MAP_MAP_SVH

// Register indices; the byte address on the bus is four times the index
`define RAM_POS_IDX 8'h10
`define REG_POS_IDX 8'h11
`define EE_POS_IDX 8'h12
`define MISC_IDX 8'h13

// Field positions
`define POS_MSB 7
`define POS_LSB 3
`define RAM_HAL_BIT 0
`define EE_ON_BIT 0
`define STR_MSB 3
`define STR_LSB 2
`define ROM_HM_BIT 1
`define ROM_ON_BIT 0

// Writable bits of each register
`define RAM_POS_MASK 8'hf9
`define REG_POS_MASK 8'h78
`define EE_POS_MASK 8'hf9
`define MISC_MASK 8'h0f

// Reset values
`define RAM_POS_RST 8'h09
`define REG_POS_RST 8'h00
`define EE_POS_RST 8'h00
`define MISC_RST 8'h0d
`define MISC_RST_TEST 8'h0c

// 1: EEPROM position bits are write-once outside special modes
`define EE_POS_WRITE_ONCE 1'b0

// Example array geometry used by the decode outputs
`define RAM_REGION_MSB 13
`define RAM_LOW_LIMIT 14'h3000
`define RAM_HIGH_START 14'h1000

`endif

// *** hdl/mem_map_pkg.sv ***
// Types shared by the memory map position control block
package mem_map_pkg;

    typedef enum logic [2:0] {
        mode_single_chip = 3'h0,
        mode_expanded = 3'h1,
        mode_emulation = 3'h2,
        mode_peripheral = 3'h3,
        mode_special_single = 3'h4,
        mode_special_expanded = 3'h5,
        mode_special_test = 3'h6
    } op_mode_t;

    typedef enum logic [3:0] {
        sel_ram = 4'h1,
        sel_reg = 4'h2,
        sel_ee = 4'h4,
        sel_misc = 4'h8
    } reg_sel_t;

endpackage

// *** hdl/memory_map_position_control.sv ***
// Map position registers over APB with decode of the resulting map
//
// The APB slave port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "mem_map_map.svh"

module memory_map_position_control
    import mem_map_pkg::*;
(
    input wire logic clk, // 40 MHz core clock
    input wire logic rst, // Synchronous reset, active high
    input wire op_mode_t op_mode, // Operating mode
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [7:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error on unmapped address
    output logic [4:0] ram_base_bits, // RAM base address [15:11]
    output logic ram_high_align, // RAM aligned high in region
    output logic [4:0] reg_base_bits, // Register base address [15:11]
    output logic [4:0] nv_array_base_bits, // EEPROM base address [15:11]
    output logic nv_array_map_enable, // EEPROM present in map
    output logic [1:0] external_stretch_count, // Stretch cycles in use
    output logic program_store_upper_half_only, // Lower fixed pages off
    output logic program_store_map_enable, // Flash present in map
    input wire logic [15:0] probe_addr, // Address to decode
    output logic ram_hit, // Address falls in RAM
    output logic reg_hit, // Address falls in register block
    output logic nv_hit, // Address falls in EEPROM
    output logic prog_hit // Address falls in flash
);

    logic [7:0] ram_pos_q;
    logic [7:0] reg_pos_q;
    logic [7:0] ee_pos_q;
    logic [7:0] misc_q;
    logic ram_lock_q;
    logic reg_lock_q;
    logic ee_lock_q;
    logic [2:0] misc_lock_q;
    logic special;
    logic once_mode;
    logic wr_en;
    logic rd_setup;
    logic mapped;
    reg_sel_t sel;
    logic [7:0] rd_byte;
    logic [13:0] ram_off;

    assign special = (op_mode == mode_special_single) ||
                     (op_mode == mode_special_expanded) ||
                     (op_mode == mode_special_test) ||
                     (op_mode == mode_peripheral);
    assign once_mode = !special;

    // Index held in the low bits of the word address
    always_comb begin
        sel = sel_ram;
        mapped = 1'b1;
        case (paddr[7:2])
            6'(`RAM_POS_IDX): sel = sel_ram;
            6'(`REG_POS_IDX): sel = sel_reg;
            6'(`EE_POS_IDX): sel = sel_ee;
            6'(`MISC_IDX): sel = sel_misc;
            default: mapped = 1'b0;
        endcase
        if (paddr[1:0] != 2'b00) begin
            mapped = 1'b0;
        end
    end

    // Zero-wait slave: every access completes in its first access cycle
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign wr_en = psel && penable && pwrite && mapped;
    assign rd_setup = psel && !penable && !pwrite;

    always_comb begin
        rd_byte = 8'h00;
        case (sel)
            sel_ram: rd_byte = ram_pos_q;
            sel_reg: rd_byte = reg_pos_q;
            sel_ee: rd_byte = ee_pos_q;
            sel_misc: rd_byte = misc_q;
            default: rd_byte = 8'h00;
        endcase
        if (!mapped) begin
            rd_byte = 8'h00;
        end
    end

    // Captured in setup so read data comes from a flop
    always_ff @(posedge clk) begin
        if (rst) begin
            prdata <= 32'h0000_0000;
        end else if (rd_setup) begin
            prdata <= {24'h00_0000, rd_byte};
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ram_pos_q <= `RAM_POS_RST;
            ram_lock_q <= 1'b0;
        end else if (wr_en && sel == sel_ram &&
                     !(once_mode && ram_lock_q)) begin
            ram_pos_q <= pwdata[7:0] & `RAM_POS_MASK;
            ram_lock_q <= once_mode;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            reg_pos_q <= `REG_POS_RST;
            reg_lock_q <= 1'b0;
        end else if (wr_en && sel == sel_reg &&
                     !(once_mode && reg_lock_q)) begin
            reg_pos_q <= pwdata[7:0] & `REG_POS_MASK;
            reg_lock_q <= once_mode;
        end
    end

    // Enable bit is never locked; position bits only when configured so
    always_ff @(posedge clk) begin
        if (rst) begin
            ee_pos_q <= `EE_POS_RST;
            ee_lock_q <= 1'b0;
        end else if (wr_en && sel == sel_ee) begin
            ee_pos_q[`EE_ON_BIT] <= pwdata[`EE_ON_BIT];
            if (!(`EE_POS_WRITE_ONCE && once_mode && ee_lock_q)) begin
                ee_pos_q[`POS_MSB:`POS_LSB] <=
                    pwdata[`POS_MSB:`POS_LSB];
                ee_lock_q <= `EE_POS_WRITE_ONCE && once_mode;
            end
        end
    end

    // Bits 7:4 of the reset value hold zero and never change
    always_ff @(posedge clk) begin
        if (rst) begin
            misc_lock_q <= 3'b000;
            if (op_mode == mode_special_test) begin
                misc_q <= `MISC_RST_TEST;
            end else begin
                misc_q <= `MISC_RST;
            end
        end else if (wr_en && sel == sel_misc) begin
            if (!(once_mode && misc_lock_q[2])) begin
                misc_q[`STR_MSB:`STR_LSB] <=
                    pwdata[`STR_MSB:`STR_LSB];
                misc_lock_q[2] <= once_mode;
            end
            if (!(once_mode && misc_lock_q[1])) begin
                misc_q[`ROM_HM_BIT] <= pwdata[`ROM_HM_BIT];
                misc_lock_q[1] <= once_mode;
            end
            if (!(once_mode && misc_lock_q[0])) begin
                misc_q[`ROM_ON_BIT] <= pwdata[`ROM_ON_BIT];
                misc_lock_q[0] <= once_mode;
            end
        end
    end

    // Map copies lag the registers by one cycle so a write never
    // changes decode in the cycle that performs it
    always_ff @(posedge clk) begin
        if (rst) begin
            ram_base_bits <= 5'(`RAM_POS_RST >> `POS_LSB);
            ram_high_align <= 1'b1;
            reg_base_bits <= 5'h00;
            nv_array_base_bits <= 5'h00;
            nv_array_map_enable <= 1'b0;
            external_stretch_count <= 2'b00;
            program_store_upper_half_only <= 1'b0;
            program_store_map_enable <= 1'b0;
        end else begin
            ram_base_bits <= ram_pos_q[`POS_MSB:`POS_LSB];
            ram_high_align <= ram_pos_q[`RAM_HAL_BIT];
            reg_base_bits <= {1'b0, reg_pos_q[6:3]};
            nv_array_base_bits <= ee_pos_q[`POS_MSB:`POS_LSB];
            nv_array_map_enable <= ee_pos_q[`EE_ON_BIT];
            program_store_upper_half_only <= misc_q[`ROM_HM_BIT];
            program_store_map_enable <= misc_q[`ROM_ON_BIT];
            if (op_mode == mode_single_chip ||
                op_mode == mode_special_single ||
                op_mode == mode_peripheral) begin
                external_stretch_count <= 2'b00;
            end else begin
                external_stretch_count <=
                    misc_q[`STR_MSB:`STR_LSB];
            end
        end
    end

    // Decode of a probe address against the current map
    assign ram_off = probe_addr[`RAM_REGION_MSB:0];
    always_comb begin
        reg_hit = probe_addr[15:11] == reg_base_bits;
        ram_hit = 1'b0;
        if (probe_addr[15:14] == ram_base_bits[4:3]) begin
            if (ram_high_align) begin
                ram_hit = ram_off >= `RAM_HIGH_START;
            end else begin
                ram_hit = ram_off < `RAM_LOW_LIMIT;
            end
        end
        nv_hit = nv_array_map_enable &&
                 probe_addr[15:11] == nv_array_base_bits;
        prog_hit = program_store_map_enable &&
                   (probe_addr[15] || (probe_addr[14] &&
                    !program_store_upper_half_only));
        if (reg_hit) begin
            ram_hit = 1'b0;
            nv_hit = 1'b0;
            prog_hit = 1'b0;
        end else if (ram_hit) begin
            nv_hit = 1'b0;
            prog_hit = 1'b0;
        end else if (nv_hit) begin
            prog_hit = 1'b0;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_wr_ram;
        psel && penable && pwrite && paddr == 8'(`RAM_POS_IDX * 4);
    endsequence

    sequence s_wr_misc;
        psel && penable && pwrite && paddr == 8'(`MISC_IDX * 4);
    endsequence

    property p_ram_once;
        s_wr_ram ##0 (ram_lock_q && once_mode) |=> $stable(ram_pos_q);
    endproperty
    a_ram_once: assert property (p_ram_once)
        else $error("locked RAM position changed");

    property p_ram_special;
        s_wr_ram ##0 special |=>
            ram_pos_q == ($past(pwdata[7:0]) & `RAM_POS_MASK);
    endproperty
    a_ram_special: assert property (p_ram_special)
        else $error("special-mode RAM write not taken");

    property p_map_lag;
        $changed(ram_pos_q) |->
            ram_base_bits == $past(ram_base_bits) ##1
            ram_base_bits == $past(ram_pos_q[7:3]);
    endproperty
    a_map_lag: assert property (p_map_lag)
        else $error("RAM map not updated one cycle after write");

    property p_reg_once;
        psel && penable && pwrite && paddr == 8'(`REG_POS_IDX * 4)
            && reg_lock_q && once_mode |=> $stable(reg_pos_q);
    endproperty
    a_reg_once: assert property (p_reg_once)
        else $error("locked register position changed");

    property p_misc_once;
        s_wr_misc ##0 (misc_lock_q == 3'b111 && once_mode) ##1 1
            |-> $stable(misc_q);
    endproperty
    a_misc_once: assert property (p_misc_once)
        else $error("locked misc register changed");

    property p_stretch_gate;
        (op_mode == mode_single_chip || op_mode == mode_peripheral)
            [*2] |-> external_stretch_count == 2'b00;
    endproperty
    a_stretch_gate: assert property (p_stretch_gate)
        else $error("stretch active in single-chip mode");

    property p_stretch_follow;
        !(op_mode == mode_single_chip || op_mode == mode_special_single ||
          op_mode == mode_peripheral) |=>
            external_stretch_count == $past(misc_q[`STR_MSB:`STR_LSB]);
    endproperty
    a_stretch_follow: assert property (p_stretch_follow)
        else $error("stretch count not following register");

    property p_ee_enable_free;
        psel && penable && pwrite && paddr == 8'(`EE_POS_IDX * 4) |=>
            ee_pos_q[`EE_ON_BIT] == $past(pwdata[`EE_ON_BIT]);
    endproperty
    a_ee_enable_free: assert property (p_ee_enable_free)
        else $error("EEPROM enable write not taken");

    property p_ee_off;
        !nv_array_map_enable |-> !nv_hit;
    endproperty
    a_ee_off: assert property (p_ee_off)
        else $error("EEPROM decoded while disabled");

    property p_rom_half;
        program_store_upper_half_only && probe_addr[15:14] == 2'b01
            |-> !prog_hit;
    endproperty
    a_rom_half: assert property (p_rom_half)
        else $error("lower fixed flash page decoded");

    property p_rom_off;
        !program_store_map_enable |-> !prog_hit;
    endproperty
    a_rom_off: assert property (p_rom_off)
        else $error("flash decoded while disabled");

    property p_reserved_zero;
        psel && penable && !pwrite |->
            prdata[31:8] == 24'h00_0000 && (prdata[2:1] == 2'b00 ||
            paddr == 8'(`MISC_IDX * 4));
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved read bits not zero");

    property p_reset_vals;
        $fell(rst) |-> ram_pos_q == `RAM_POS_RST &&
            misc_q[3:1] == 3'b110;
    endproperty
    a_reset_vals: assert property (@(posedge clk) p_reset_vals)
        else $error("wrong reset values");

endmodule
`default_nettype wire

// *** testbench/core_bus_model.sv ***
// Core bus side: presents an address to the decoder and gathers the selects
`timescale 1ns/1ps
`default_nettype none
module core_bus_model (
    input wire logic clk, // Core clock
    input wire logic [15:0] want, // Address the core wants
    output logic [15:0] probe_addr, // Address on the core bus
    input wire logic ram_hit, // RAM select
    input wire logic reg_hit, // Register block select
    input wire logic nv_hit, // EEPROM select
    input wire logic prog_hit, // Flash select
    output logic [3:0] hits // Selects as reg, ram, nv, prog
);
    logic [15:0] addr_q = 16'h0000;
    // Core launches its address one edge after asking
    always @(posedge clk) begin
        addr_q <= want;
    end
    assign probe_addr = addr_q;
    assign hits = {reg_hit, ram_hit, nv_hit, prog_hit};
endmodule
`default_nettype wire

// *** testbench/tb_memory_map_position_control.sv ***
// Self-checking bench for the map position registers
`timescale 1ns/1ps
`default_nettype none
`include "mem_map_map.svh"
module tb_memory_map_position_control;
    import mem_map_pkg::*;
    localparam logic [7:0] a_ram = 8'(`RAM_POS_IDX * 4);
    localparam logic [7:0] a_reg = 8'(`REG_POS_IDX * 4);
    localparam logic [7:0] a_ee = 8'(`EE_POS_IDX * 4);
    localparam logic [7:0] a_misc = 8'(`MISC_IDX * 4);
    logic clk = 1'b0;
    logic rst = 1'b1;
    op_mode_t op_mode = mode_expanded;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rdat;
    logic pready, pslverr, rerr, ram_high_align, nv_array_map_enable;
    logic [4:0] ram_base_bits, reg_base_bits, nv_array_base_bits;
    logic [1:0] external_stretch_count;
    logic program_store_upper_half_only, program_store_map_enable;
    logic [15:0] want = 16'h0000;
    logic [15:0] probe_addr;
    logic ram_hit, reg_hit, nv_hit, prog_hit;
    logic [3:0] hits;
    int err_total = 0;
    int compares = 0;
    int cycles = 0;

    memory_map_position_control dut (.clk(clk), .rst(rst),
        .op_mode(op_mode), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ram_base_bits(ram_base_bits),
        .ram_high_align(ram_high_align), .reg_base_bits(reg_base_bits),
        .nv_array_base_bits(nv_array_base_bits),
        .nv_array_map_enable(nv_array_map_enable),
        .external_stretch_count(external_stretch_count),
        .program_store_upper_half_only(program_store_upper_half_only),
        .program_store_map_enable(program_store_map_enable),
        .probe_addr(probe_addr), .ram_hit(ram_hit), .reg_hit(reg_hit),
        .nv_hit(nv_hit), .prog_hit(prog_hit));
    core_bus_model core (.clk(clk), .want(want), .probe_addr(probe_addr),
        .ram_hit(ram_hit), .reg_hit(reg_hit), .nv_hit(nv_hit),
        .prog_hit(prog_hit), .hits(hits));

    initial begin
        forever #12.5 clk = ~clk;
    end

    task automatic close_out();
        $display("checks %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Hang guard, well above the two hundred or so cycles the run needs
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            close_out();
        end
    end

    task automatic chk(input string w, input logic [31:0] e,
                       input logic [31:0] g);
        compares++;
        if (g !== e) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", w, e, g);
        end
    endtask

    task automatic do_reset(input op_mode_t m);
        op_mode <= m;
        rst <= 1'b1;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
    endtask

    // Idle edge first so psel is never assigned twice in one step
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 100);
        if (n >= 100) begin
            err_total++;
            $display("mismatch pready expected 1 seen %b", pready);
        end
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h0, d});
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e, string w);
        apb(1'b0, a, 32'h0);
        chk(w, {24'h0, e}, rdat);
    endtask

    task automatic probe(input logic [15:0] a, input logic [3:0] e);
        @(posedge clk);
        want <= a;
        @(posedge clk);
        #1;
        chk("selects", {28'h0, e}, {28'h0, hits});
    endtask

    task automatic t_reset_values();
        do_reset(mode_expanded);
        rd(a_ram, 8'h09, "ram pos");
        rd(a_reg, 8'h00, "reg pos");
        rd(a_ee, 8'h00, "ee pos");
        rd(a_misc, 8'h0d, "misc");
        chk("ram base", 32'h1, {27'h0, ram_base_bits});
        chk("high align", 32'h1, {31'h0, ram_high_align});
        chk("stretch", 32'h3, {30'h0, external_stretch_count});
        chk("flash on", 32'h1, {31'h0, program_store_map_enable});
        chk("half", 32'h0, {31'h0, program_store_upper_half_only});
        chk("ee on", 32'h0, {31'h0, nv_array_map_enable});
        chk("ee base", 32'h0, {27'h0, nv_array_base_bits});
        probe(16'hc000, 4'b0001);
        probe(16'h2000, 4'b0100);
    endtask

    task automatic t_ram_once();
        do_reset(mode_single_chip);
        wr(a_ram, 8'h40);
        #1;
        chk("ram base early", 32'h1, {27'h0, ram_base_bits});
        @(posedge clk);
        #1;
        chk("ram base late", 32'h8, {27'h0, ram_base_bits});
        chk("stretch off", 32'h0, {30'h0, external_stretch_count});
        wr(a_ram, 8'h09);
        rd(a_ram, 8'h40, "ram locked");
        probe(16'h4800, 4'b0100);
        probe(16'h7800, 4'b0001);
    endtask

    task automatic t_special();
        do_reset(mode_special_test);
        rd(a_misc, 8'h0c, "misc test");
        probe(16'hc000, 4'b0000);
        wr(a_ram, 8'hff);
        rd(a_ram, 8'hf9, "ram unused bits");
        wr(a_ram, 8'h09);
        rd(a_ram, 8'h09, "ram again");
        wr(a_reg, 8'hff);
        rd(a_reg, 8'h78, "reg pos");
        wr(a_reg, 8'h08);
        rd(a_reg, 8'h08, "reg again");
        chk("reg base", 32'h1, {27'h0, reg_base_bits});
        probe(16'h0800, 4'b1000);
    endtask

    task automatic t_misc();
        do_reset(mode_special_expanded);
        for (int s = 0; s < 4; s++) begin
            wr(a_misc, {4'h0, 2'(s), 2'b01});
            @(posedge clk);
            #1;
            chk("stretch", 32'(s), {30'h0, external_stretch_count});
        end
        probe(16'h7000, 4'b0001);
        wr(a_misc, 8'h03);
        probe(16'h7000, 4'b0000);
        chk("half", 32'h1, {31'h0, program_store_upper_half_only});
        probe(16'hc000, 4'b0001);
        do_reset(mode_emulation);
        wr(a_misc, 8'h00);
        wr(a_misc, 8'h0f);
        rd(a_misc, 8'h00, "misc locked");
        probe(16'hc000, 4'b0000);
    endtask

    task automatic t_ee();
        do_reset(mode_expanded);
        wr(a_reg, 8'h10);
        wr(a_reg, 8'h20);
        rd(a_reg, 8'h10, "reg locked");
        probe(16'h1000, 4'b1000);
        wr(a_ee, 8'h51);
        rd(a_ee, 8'h51, "ee pos");
        chk("ee base", 32'h0a, {27'h0, nv_array_base_bits});
        probe(16'h5000, 4'b0010);
        wr(a_ee, 8'h89);
        probe(16'h8800, 4'b0010);
        wr(a_ee, 8'h88);
        probe(16'h8800, 4'b0001);
        chk("ee on", 32'h0, {31'h0, nv_array_map_enable});
        apb(1'b0, 8'h50, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, rerr});
        chk("unmapped data", 32'h0, rdat);
    endtask

    // Peripheral and special single-chip: free writes, no stretch
    task automatic t_periph();
        do_reset(mode_peripheral);
        wr(a_misc, 8'h00);
        wr(a_misc, 8'h0e);
        rd(a_misc, 8'h0e, "misc free");
        chk("stretch pm", 32'h0, {30'h0, external_stretch_count});
        do_reset(mode_special_single);
        wr(a_misc, 8'h0c);
        rd(a_misc, 8'h0c, "misc single");
        chk("stretch ss", 32'h0, {30'h0, external_stretch_count});
        probe(16'hc000, 4'b0000);
    endtask

    initial begin
        t_reset_values();
        t_ram_once();
        t_special();
        t_misc();
        t_ee();
        t_periph();
        close_out();
    end
endmodule
`default_nettype wire
